// [logic/ppr_event_report.sv]
/*
 * ppr_event_report: link event mailbox with pending and lost flags,
 * event code table, clock watchdogs and received-unit timer, reached by
 * software over an Avalon-MM slave with waitrequest.
 * assumes the protocol engine drives one-cycle event pulses on clk_in
 * and the bit clocks arrive asynchronously on pins.
 */
// Design decisions made here: the Avalon-MM slave port and the register addresses.
// Operation
// - new event while pending is set and no host clear raises lost flag, code not delivered
// - lost flag clears with pending and on reset; host writes ignored
// - pending flag sets when a new code is loaded
// - pending clears only by host write of one or reset
// - code and pending flag update in the same cycle
// - code 0 on init done, code 1 on alignment success
// - code 2 for old-format alignment only when yellow option enabled
// - code 3 when transmit bit clock idles beyond selected limit
// - code 4 when receive bit clock idles beyond selected limit
// - code 5 when no unit within 32 poll periods, timer enabled
// - code 8 on out of service from alignment failure
// - code 9 on out of service from received status unit
// - code 10 on out of service from T1 expiry
// - code 11 on out of service from transmit link failure
// - code 12 on out of service from receive link failure
// - code 13 on out of service from error rate monitor
// - code 16 on remote outage, code 17 on later fill-in or message
// - code 18 after last backward sequence number is stored
// - code 19 when retrieval with forward sequence number completes
// - code 20 on remote busy, code 21 when congestion ends
`timescale 1ns/1ns
module ppr_event_report (
    input wire logic clk_in,                  // 125 MHz system clock
    input wire logic rst_b_in,                // async bus reset, active low
    input wire logic [3:0] avs_address,       // byte address
    input wire logic avs_read,                // read request
    input wire logic avs_write,               // write request
    input wire logic [31:0] avs_writedata,    // write data
    input wire logic [3:0] avs_byteenable,    // byte lanes
    output logic [31:0] avs_readdata,         // read data
    output logic avs_waitrequest,             // stall
    input wire logic init_done_in,            // initialisation finished
    input wire logic align_done_in,           // alignment succeeded
    input wire logic align_old_sf_in,         // alignment used old sf values
    input wire logic align_fail_in,           // aerm, t2 or t3 failure
    input wire logic lssu_oos_in,             // oos by received lssu
    input wire logic t1_oos_in,               // oos by t1 expiry
    input wire logic tx_fail_in,              // t6 or t7 expiry
    input wire logic rx_fail_in,              // fib/bsn error 2 of 3
    input wire logic suerm_oos_in,            // error rate monitor
    input wire logic outage_rx_in,            // processor outage unit seen
    input wire logic fill_or_msg_rx_in,       // fill-in or message unit seen
    input wire logic bsnt_stored_in,          // bsnt in status buffer
    input wire logic retrieval_done_in,       // retrieval with fsnc done
    input wire logic busy_rx_in,              // busy unit seen
    input wire logic msg_acked_in,            // remote acked a message unit
    input wire logic unit_rx_in,              // any signal unit received
    input wire logic transmit_bit_clock_in,   // transmit bit clock pin
    input wire logic receive_bit_clock_in,    // receive bit clock pin
    output logic event_pending_flag_out,      // pending flag
    output logic event_lost_flag_out,         // lost flag
    output logic [5:0] link_event_code_out    // posted code
);
    logic event_pending_flag_q, event_lost_flag_q;
    logic [5:0] link_event_code_q;
    logic [15:0] clock_watchdog_config_q, poll_timer_period_q;
    logic yellow_book_report_enable_q, rx_unit_timer_enable_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic outage_seen_q, busy_seen_q;
    logic [15:0] poll_cnt_q;
    logic [5:0] rsu_cnt_q;
    logic rsu_fired_q;
    logic tx_wd_exp, rx_wd_exp, poll_tick, rsu_exp;
    logic [ppr_pkg::EV_NUM-1:0] ev;
    logic any_ev, multi_ev, host_clear, wr_take, rd_take;
    logic [5:0] new_code;

    // merge written bytes of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // code for an event slot
    function automatic logic [5:0] slot_code(input int idx,
                                             input logic yellow);
        case (idx)
            ppr_pkg::EV_INIT: slot_code = ppr_pkg::C_INIT;
            ppr_pkg::EV_ALIGN: slot_code = yellow ? ppr_pkg::C_YELLOW
                                                  : ppr_pkg::C_INSERV;
            ppr_pkg::EV_TXWD: slot_code = ppr_pkg::C_TXWD;
            ppr_pkg::EV_RXWD: slot_code = ppr_pkg::C_RXWD;
            ppr_pkg::EV_RSU: slot_code = ppr_pkg::C_RSU;
            ppr_pkg::EV_AERM: slot_code = ppr_pkg::C_AERM;
            ppr_pkg::EV_LSSU: slot_code = ppr_pkg::C_LSSU;
            ppr_pkg::EV_T1: slot_code = ppr_pkg::C_T1;
            ppr_pkg::EV_TXF: slot_code = ppr_pkg::C_TXF;
            ppr_pkg::EV_RXF: slot_code = ppr_pkg::C_RXF;
            ppr_pkg::EV_SUERM: slot_code = ppr_pkg::C_SUERM;
            ppr_pkg::EV_RPO: slot_code = ppr_pkg::C_RPO;
            ppr_pkg::EV_RPOR: slot_code = ppr_pkg::C_RPOR;
            ppr_pkg::EV_BSNT: slot_code = ppr_pkg::C_BSNT;
            ppr_pkg::EV_RETR: slot_code = ppr_pkg::C_RETR;
            ppr_pkg::EV_BUSY: slot_code = ppr_pkg::C_BUSY;
            default: slot_code = ppr_pkg::C_BUSYR;
        endcase
    endfunction : slot_code

    // bit clock watchdogs on the configured limits
    ppr_watchdog u_tx_wd (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .bit_clk_in(transmit_bit_clock_in),
        .sel_in(clock_watchdog_config_q[ppr_pkg::TXWD_LSB +: 2]),
        .expire_out(tx_wd_exp)
    );
    ppr_watchdog u_rx_wd (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .bit_clk_in(receive_bit_clock_in),
        .sel_in(clock_watchdog_config_q[ppr_pkg::RXWD_LSB +: 2]),
        .expire_out(rx_wd_exp)
    );

    // bus handshake: one wait cycle, then the request is taken
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign wr_take = avs_write && ack_q;
    assign rd_take = avs_read && ack_q;
    assign avs_readdata = rdata_q;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    // read data captured in the wait cycle; unmapped reads give zero
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            case (avs_address)
                ppr_pkg::ADDR_STATUS: rdata_q <= {24'h00_0000,
                    event_lost_flag_q, event_pending_flag_q,
                    link_event_code_q};
                ppr_pkg::ADDR_WDCFG: rdata_q <= {16'h0000,
                    clock_watchdog_config_q};
                ppr_pkg::ADDR_OPTIONS: rdata_q <= {30'h0000_0000,
                    rx_unit_timer_enable_q, yellow_book_report_enable_q};
                ppr_pkg::ADDR_POLL: rdata_q <= {16'h0000,
                    poll_timer_period_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            clock_watchdog_config_q <= ppr_pkg::WDCFG_RST;
            poll_timer_period_q <= ppr_pkg::POLL_RST;
            yellow_book_report_enable_q <= ppr_pkg::OPTIONS_RST[0];
            rx_unit_timer_enable_q <= ppr_pkg::OPTIONS_RST[1];
        end else if (wr_take) begin
            if (avs_address == ppr_pkg::ADDR_WDCFG) begin
                clock_watchdog_config_q <= merge16(clock_watchdog_config_q,
                    avs_writedata, avs_byteenable);
            end
            if (avs_address == ppr_pkg::ADDR_POLL) begin
                poll_timer_period_q <= merge16(poll_timer_period_q,
                    avs_writedata, avs_byteenable);
            end
            if (avs_address == ppr_pkg::ADDR_OPTIONS &&
                avs_byteenable[0]) begin
                yellow_book_report_enable_q <=
                    avs_writedata[ppr_pkg::YELLOW_BIT];
                rx_unit_timer_enable_q <= avs_writedata[ppr_pkg::UNIT_TMR_BIT];
            end
        end
    end

    // poll timer divider: one-cycle tick every poll period
    assign poll_tick = (poll_cnt_q >= poll_timer_period_q);
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            poll_cnt_q <= 16'h0000;
        end else if (poll_tick) begin
            poll_cnt_q <= 16'h0000;
        end else begin
            poll_cnt_q <= poll_cnt_q + 16'h0001;
        end
    end

    // received-unit timer: counts poll periods since the last unit
    assign rsu_exp = rx_unit_timer_enable_q && !rsu_fired_q &&
                     (rsu_cnt_q >= ppr_pkg::RSU_PERIODS);
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rsu_cnt_q <= 6'h00;
            rsu_fired_q <= 1'b0;
        end else if (unit_rx_in || !rx_unit_timer_enable_q) begin
            rsu_cnt_q <= 6'h00;
            rsu_fired_q <= 1'b0;
        end else begin
            if (poll_tick && rsu_cnt_q < ppr_pkg::RSU_PERIODS) begin
                rsu_cnt_q <= rsu_cnt_q + 6'h01;
            end
            if (rsu_exp) begin
                rsu_fired_q <= 1'b1;
            end
        end
    end

    // outage and congestion history for the recovery codes
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            outage_seen_q <= 1'b0;
            busy_seen_q <= 1'b0;
        end else begin
            if (outage_rx_in) begin
                outage_seen_q <= 1'b1;
            end else if (fill_or_msg_rx_in) begin
                outage_seen_q <= 1'b0;
            end
            if (busy_rx_in) begin
                busy_seen_q <= 1'b1;
            end else if (msg_acked_in) begin
                busy_seen_q <= 1'b0;
            end
        end
    end

    // event vector in priority order, lowest slot first
    always_comb begin
        ev = '0;
        ev[ppr_pkg::EV_INIT] = init_done_in;
        ev[ppr_pkg::EV_ALIGN] = align_done_in;
        ev[ppr_pkg::EV_TXWD] = tx_wd_exp;
        ev[ppr_pkg::EV_RXWD] = rx_wd_exp;
        ev[ppr_pkg::EV_RSU] = rsu_exp;
        ev[ppr_pkg::EV_AERM] = align_fail_in;
        ev[ppr_pkg::EV_LSSU] = lssu_oos_in;
        ev[ppr_pkg::EV_T1] = t1_oos_in;
        ev[ppr_pkg::EV_TXF] = tx_fail_in;
        ev[ppr_pkg::EV_RXF] = rx_fail_in;
        ev[ppr_pkg::EV_SUERM] = suerm_oos_in;
        ev[ppr_pkg::EV_RPO] = outage_rx_in;
        ev[ppr_pkg::EV_RPOR] = fill_or_msg_rx_in && outage_seen_q;
        ev[ppr_pkg::EV_BSNT] = bsnt_stored_in;
        ev[ppr_pkg::EV_RETR] = retrieval_done_in;
        ev[ppr_pkg::EV_BUSY] = busy_rx_in;
        ev[ppr_pkg::EV_BUSYR] = msg_acked_in && busy_seen_q;
    end

    // pick the first event; a second one in the same cycle is lost
    always_comb begin
        new_code = ppr_pkg::C_INIT;
        any_ev = 1'b0;
        multi_ev = 1'b0;
        for (int i = ppr_pkg::EV_NUM - 1; i >= 0; i--) begin
            if (ev[i]) begin
                multi_ev = multi_ev || any_ev;
                any_ev = 1'b1;
                new_code = slot_code(i, yellow_book_report_enable_q &&
                                        align_old_sf_in);
            end
        end
    end

    // host clear: write of one to the pending bit, lane 0
    assign host_clear = wr_take && avs_address == ppr_pkg::ADDR_STATUS &&
                        avs_byteenable[0] &&
                        avs_writedata[ppr_pkg::PEND_BIT];

    // mailbox: a post in the clearing cycle wins and is delivered
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            event_pending_flag_q <= 1'b0;
            event_lost_flag_q <= 1'b0;
            link_event_code_q <= ppr_pkg::C_INIT;
        end else if (any_ev && (!event_pending_flag_q || host_clear)) begin
            event_pending_flag_q <= 1'b1;
            link_event_code_q <= new_code;
            event_lost_flag_q <= multi_ev;
        end else if (any_ev) begin
            event_lost_flag_q <= 1'b1;
        end else if (host_clear) begin
            event_pending_flag_q <= 1'b0;
            event_lost_flag_q <= 1'b0;
        end
    end

    assign event_pending_flag_out = event_pending_flag_q;
    assign event_lost_flag_out = event_lost_flag_q;
    assign link_event_code_out = link_event_code_q;

    // checks next to the mailbox, all on the system clock
    default clocking cb_chk @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    a_lost_on_busy: assert property (
        any_ev && event_pending_flag_q && !host_clear
        |=> event_lost_flag_q && $stable(link_event_code_q))
        else $error("busy mailbox did not flag a lost event");
    a_lost_cleared: assert property (
        host_clear && !any_ev |=> !event_lost_flag_q && !event_pending_flag_q)
        else $error("lost flag survived a pending clear");
    a_post_sets: assert property (
        any_ev && !event_pending_flag_q
        |=> event_pending_flag_q && link_event_code_q == $past(new_code))
        else $error("post did not load code and pending");
    a_pend_hold: assert property (
        event_pending_flag_q && !host_clear |=> event_pending_flag_q)
        else $error("pending cleared without host write");
    a_code_hold: assert property (
        event_pending_flag_q && !host_clear |=> $stable(link_event_code_q))
        else $error("code changed while pending");
    a_yellow_gate: assert property (
        $rose(event_pending_flag_q) && link_event_code_q == ppr_pkg::C_YELLOW
        |-> $past(yellow_book_report_enable_q))
        else $error("yellow code posted while disabled");
    a_align_code: assert property (
        align_done_in && !align_old_sf_in && !ev[ppr_pkg::EV_INIT] &&
        !event_pending_flag_q |=> link_event_code_q == ppr_pkg::C_INSERV)
        else $error("alignment success gave wrong code");
    a_rsu_window: assert property (
        rsu_exp |-> rx_unit_timer_enable_q &&
        rsu_cnt_q == ppr_pkg::RSU_PERIODS)
        else $error("unit timer fired off its count");
    a_rpo_order: assert property (
        $rose(event_pending_flag_q) && link_event_code_q == ppr_pkg::C_RPOR
        |-> $past(outage_seen_q))
        else $error("outage recovery without outage");
endmodule : ppr_event_report

// [logic/ppr_watchdog.sv]
/*
 * ppr_pkg: constants for the link event reporting block.
 * ppr_watchdog: bit clock watchdog, one per link direction.
 * assumes one 125 MHz system clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ns
package ppr_pkg;
    // register byte offsets
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_WDCFG = 4'h4;
    localparam logic [3:0] ADDR_OPTIONS = 4'h8;
    localparam logic [3:0] ADDR_POLL = 4'hC;
    // status register fields
    localparam int LOST_BIT = 7;
    localparam int PEND_BIT = 6;
    localparam int CODE_MSB = 5;
    // watchdog config fields
    localparam int TXWD_LSB = 14;
    localparam int RXWD_LSB = 12;
    // options register fields
    localparam int YELLOW_BIT = 0;
    localparam int UNIT_TMR_BIT = 1;
    // reset values
    localparam logic [15:0] WDCFG_RST = 16'h0000;
    localparam logic [1:0] OPTIONS_RST = 2'h0;
    localparam logic [15:0] POLL_RST = 16'h04E2;
    // watchdog limits in system clock cycles, chosen by a two-bit field
    localparam logic [15:0] WD_LIM0 = 16'h0040;
    localparam logic [15:0] WD_LIM1 = 16'h0100;
    localparam logic [15:0] WD_LIM2 = 16'h0400;
    localparam logic [15:0] WD_LIM3 = 16'h1000;
    // poll periods without a received unit before timeout
    localparam logic [5:0] RSU_PERIODS = 6'h20;
    // event slots on the event vector
    localparam int EV_INIT = 0;
    localparam int EV_ALIGN = 1;
    localparam int EV_TXWD = 2;
    localparam int EV_RXWD = 3;
    localparam int EV_RSU = 4;
    localparam int EV_AERM = 5;
    localparam int EV_LSSU = 6;
    localparam int EV_T1 = 7;
    localparam int EV_TXF = 8;
    localparam int EV_RXF = 9;
    localparam int EV_SUERM = 10;
    localparam int EV_RPO = 11;
    localparam int EV_RPOR = 12;
    localparam int EV_BSNT = 13;
    localparam int EV_RETR = 14;
    localparam int EV_BUSY = 15;
    localparam int EV_BUSYR = 16;
    localparam int EV_NUM = 17;
    // event codes
    localparam logic [5:0] C_INIT = 6'h00;
    localparam logic [5:0] C_INSERV = 6'h01;
    localparam logic [5:0] C_YELLOW = 6'h02;
    localparam logic [5:0] C_TXWD = 6'h03;
    localparam logic [5:0] C_RXWD = 6'h04;
    localparam logic [5:0] C_RSU = 6'h05;
    localparam logic [5:0] C_AERM = 6'h08;
    localparam logic [5:0] C_LSSU = 6'h09;
    localparam logic [5:0] C_T1 = 6'h0A;
    localparam logic [5:0] C_TXF = 6'h0B;
    localparam logic [5:0] C_RXF = 6'h0C;
    localparam logic [5:0] C_SUERM = 6'h0D;
    localparam logic [5:0] C_RPO = 6'h10;
    localparam logic [5:0] C_RPOR = 6'h11;
    localparam logic [5:0] C_BSNT = 6'h12;
    localparam logic [5:0] C_RETR = 6'h13;
    localparam logic [5:0] C_BUSY = 6'h14;
    localparam logic [5:0] C_BUSYR = 6'h15;
endpackage : ppr_pkg

module ppr_watchdog (
    input wire logic clk_in,          // system clock
    input wire logic rst_b_in,        // async reset, active low
    input wire logic bit_clk_in,      // bit clock pin, asynchronous
    input wire logic [1:0] sel_in,    // limit select
    output logic expire_out           // one-cycle pulse on timeout
);
    logic sync1_q, sync2_q, last_q, fired_q;
    logic [15:0] cnt_q;
    logic [15:0] limit;

    // limit lookup from the select field
    always_comb begin
        case (sel_in)
            2'd0: limit = ppr_pkg::WD_LIM0;
            2'd1: limit = ppr_pkg::WD_LIM1;
            2'd2: limit = ppr_pkg::WD_LIM2;
            default: limit = ppr_pkg::WD_LIM3;
        endcase
    end

    // two-stage synchroniser, then edge history
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            sync1_q <= bit_clk_in;
            sync2_q <= sync1_q;
            last_q <= sync2_q;
        end
    end

    // count quiet cycles; fire once per stall, re-arm on a transition
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= 16'h0000;
            fired_q <= 1'b0;
        end else if (sync2_q != last_q) begin
            cnt_q <= 16'h0000;
            fired_q <= 1'b0;
        end else if (cnt_q > limit) begin
            fired_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign expire_out = (cnt_q > limit) && !fired_q && (sync2_q == last_q);
endmodule : ppr_watchdog

// [tb/ppr_host_model.sv]
/*
 * ppr_host_model: host side of the event block, Avalon-MM master tasks
 * and the two bit clock pins. assumes waitrequest is judged at rising
 * edges of clk_in and that tasks are called from one process at a time.
 */
`timescale 1ns/1ns
module ppr_host_model (
    input wire logic clk_in,          // system clock
    input wire logic wait_in,         // slave stall
    input wire logic [31:0] rdata_in, // read data
    input wire logic tx_run_in,       // transmit bit clock runs
    input wire logic rx_run_in,       // receive bit clock runs
    output logic [3:0] addr_out,      // byte address
    output logic rd_out,              // read request
    output logic wr_out,              // write request
    output logic [31:0] wdata_out,    // write data
    output logic txc_out,             // transmit bit clock
    output logic rxc_out,             // receive bit clock
    output logic bus_err_out          // a transfer never completed
);
    // idle bus at time zero
    initial begin
        {addr_out, rd_out, wr_out, wdata_out} = '0;
        {txc_out, rxc_out, bus_err_out} = '0;
    end
    // bit clocks, unrelated in phase to clk_in, stopped on request
    always #12 if (tx_run_in) txc_out = ~txc_out;
    always #20 if (rx_run_in) rxc_out = ~rxc_out;
    // one transfer, held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic w, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        rd_out <= !w;
        wr_out <= w;
        n = 0;
        @(posedge clk_in);
        while (wait_in !== 1'b0 && n < 20) begin
            @(posedge clk_in);
            n++;
        end
        q = rdata_in;
        if (n >= 20) bus_err_out <= 1'b1;
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        // let the taken edge settle before the caller looks at flags
        @(negedge clk_in);
    endtask : xfer
    // clears the pending flag by writing one to the pending bit of status
    task automatic clear_pending();
        logic [31:0] q;
        xfer(1'b1, 4'h0, 32'h0000_0040, q);
    endtask : clear_pending
endmodule : ppr_host_model

// [tb/tb_ppr_event_report.sv]
/*
 * tb_ppr_event_report: directed tests of the event mailbox.
 * assumes event inputs are one-cycle pulses and POLL may be shortened.
 */
`timescale 1ns/1ns
module tb_ppr_event_report;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [13:0] ev = '0;
    logic old_sf = 1'b0;
    logic unit_rx = 1'b0;
    logic tx_run = 1'b1;
    logic rx_run = 1'b1;
    logic [3:0] addr;
    logic rd, wr, wait_r, bus_err, txc, rxc, pend, lost;
    logic [31:0] wdata, rdata, q;
    logic [5:0] code;
    int error_cnt = 0;
    int checked = 0;
    logic [5:0] codes [14] = '{0, 1, 8, 9, 10, 11, 12, 13, 16, 17, 18, 19,
                               20, 21};
    // system clock, 8 ns
    always #4 clk_in = ~clk_in;
    ppr_event_report dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(wait_r), .init_done_in(ev[0]),
        .align_done_in(ev[1]), .align_old_sf_in(old_sf),
        .align_fail_in(ev[2]), .lssu_oos_in(ev[3]), .t1_oos_in(ev[4]),
        .tx_fail_in(ev[5]), .rx_fail_in(ev[6]), .suerm_oos_in(ev[7]),
        .outage_rx_in(ev[8]), .fill_or_msg_rx_in(ev[9]),
        .bsnt_stored_in(ev[10]), .retrieval_done_in(ev[11]),
        .busy_rx_in(ev[12]), .msg_acked_in(ev[13]), .unit_rx_in(unit_rx),
        .transmit_bit_clock_in(txc), .receive_bit_clock_in(rxc),
        .event_pending_flag_out(pend), .event_lost_flag_out(lost),
        .link_event_code_out(code));
    ppr_host_model host (.clk_in(clk_in), .wait_in(wait_r),
        .rdata_in(rdata), .tx_run_in(tx_run), .rx_run_in(rx_run),
        .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wdata),
        .txc_out(txc), .rxc_out(rxc), .bus_err_out(bus_err));
    // compare and count
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic stop_test();
        if (bus_err !== 1'b0) error_cnt++;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    // one-cycle pulse on an event input, flags judged after its edge
    task automatic pulse(input int i);
        @(posedge clk_in);
        ev <= 14'h0001 << i;
        @(posedge clk_in);
        ev <= '0;
        @(negedge clk_in);
    endtask : pulse
    // bounded wait for the pending flag, returns cycles spent
    task automatic wait_pend(input int max, output int n);
        n = 0;
        while (pend !== 1'b1 && n < max) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= max) begin
            error_cnt++;
            $display("[FAIL] pending wait timed out");
            stop_test();
        end
        @(negedge clk_in);
    endtask : wait_pend
    // every event input posts its own code, read back then cleared
    task automatic t_codes();
        for (int i = 0; i < 14; i++) begin
            pulse(i);
            chk("status", {2'b01, codes[i]}, {lost, pend, code});
            host.xfer(1'b0, 4'h0, '0, q);
            chk("read status", {2'b01, codes[i]}, q[7:0]);
            host.clear_pending();
            chk("cleared", {2'b00, codes[i]}, {lost, pend, code});
        end
        $display("test codes done");
    endtask : t_codes
    // second event is lost, code kept, only a write of one or reset clears
    task automatic t_lost();
        pulse(0);
        pulse(3);
        chk("lost set", 8'hC0, {lost, pend, code});
        host.xfer(1'b1, 4'h0, 32'h0000_0080, q);
        chk("write zero", 8'hC0, {lost, pend, code});
        host.xfer(1'b0, 4'h2, '0, q);
        chk("unmapped", 8'h00, q[7:0]);
        host.clear_pending();
        chk("both clear", 8'h00, {lost, pend, code});
        pulse(0);
        pulse(3);
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(negedge clk_in);
        chk("reset", 8'h00, {lost, pend, code});
        $display("test lost done");
    endtask : t_lost
    // old-format alignment reports code 2 only when enabled
    task automatic t_yellow();
        old_sf <= 1'b1;
        for (int y = 1; y >= 0; y--) begin
            host.xfer(1'b1, 4'h8, 32'(y), q);
            pulse(1);
            chk("align", y ? 8'h42 : 8'h41, {lost, pend, code});
            host.clear_pending();
        end
        old_sf <= 1'b0;
        $display("test yellow done");
    endtask : t_yellow
    // stopped bit clocks raise their watchdog codes
    task automatic t_wdog();
        int n;
        for (int d = 0; d < 2; d++) begin
            @(posedge clk_in);
            tx_run <= (d != 0);
            rx_run <= (d == 0);
            wait_pend(300, n);
            chk("watchdog", d ? 8'h44 : 8'h43,
                {lost, pend, code});
            tx_run <= 1'b1;
            rx_run <= 1'b1;
            host.clear_pending();
        end
        $display("test watchdog done");
    endtask : t_wdog
    // 32 poll ticks of 5 cycles without a unit post code 5
    task automatic t_rsu();
        int n;
        host.xfer(1'b1, 4'hC, 32'h0000_0004, q);
        host.xfer(1'b1, 4'h8, 32'h0000_0002, q);
        wait_pend(400, n);
        chk("rsu status", 8'h45, {lost, pend, code});
        chk("rsu not early", 8'h01, {7'h00, n >= 150});
        host.xfer(1'b1, 4'h8, 32'h0000_0000, q);
        host.clear_pending();
        $display("test unit timer done");
    endtask : t_rsu
    // reset, then the scenarios in turn
    initial begin
        repeat (8) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_codes();
        t_lost();
        t_yellow();
        t_wdog();
        t_rsu();
        stop_test();
    end
    // cuts a hang short
    initial begin
        #400_000;
        error_cnt++;
        $display("[FAIL] run limit expected done seen hang");
        stop_test();
    end
endmodule : tb_ppr_event_report
